// [common/vpof_pkg.sv]
// shared constants of the video pixel output formatter
// assumes an 8-bit register port and byte-wide colour samples
package vpof_pkg;

  // register offsets
  localparam logic [7:0] ADDR_START_MSB   = 8'h14;
  localparam logic [7:0] ADDR_START_LSB   = 8'h15;
  localparam logic [7:0] ADDR_BLACK_CFG   = 8'h17;
  localparam logic [7:0] ADDR_OUT_FMT     = 8'h18;
  localparam logic [7:0] ADDR_LS_WIDTH    = 8'h19;
  localparam logic [7:0] ADDR_TRISTATE    = 8'h1A;
  localparam logic [7:0] ADDR_LEVEL_RED   = 8'h40;
  localparam logic [7:0] ADDR_LEVEL_GREEN = 8'h41;
  localparam logic [7:0] ADDR_LEVEL_BLUE  = 8'h42;

  // reset values and writable-bit masks
  localparam logic [7:0]  RST_BLACK_CFG  = 8'h40;
  localparam logic [7:0]  RST_OUT_FMT    = 8'h00;
  localparam logic [7:0]  RST_LS_WIDTH   = 8'h10;
  localparam logic [7:0]  RST_TRISTATE   = 8'h00;
  localparam logic [12:0] RST_START      = 13'h0000;
  localparam logic [7:0]  MASK_BLACK_CFG = 8'h7D;
  localparam logic [7:0]  MASK_OUT_FMT   = 8'hF7;
  localparam logic [7:0]  MASK_START_MSB = 8'h1F;

  // field positions
  localparam int BLC_DIS_BIT      = 0;
  localparam int BLC_PIX_LSB      = 2;
  localparam int BLC_BW_LSB       = 4;
  localparam int FMT_WIDE_BIT     = 0;
  localparam int FMT_IL_BIT       = 1;
  localparam int FMT_SWAP_BIT     = 2;
  localparam int FMT_DEC_BIT      = 4;
  localparam int FMT_DCLK_POL_BIT = 5;
  localparam int FMT_FS_POL_BIT   = 6;
  localparam int FMT_LS_POL_BIT   = 7;
  localparam int TS_DCLK_A_BIT    = 6;
  localparam int TS_DCLK_B_BIT    = 7;

  // black-level loop scaling
  localparam int BLC_MIN_AVG_EXP = 4;
  localparam int BLC_TC_BASE_EXP = 5;
  localparam int BLC_FRAC        = 12;

endpackage : vpof_pkg

// [core/vpof_sync2.sv]
// two-flop synchroniser for quasi-static levels
// assumes the source holds each value for many destination clocks
`timescale 1ns/1ps
`default_nettype none
module vpof_sync2 #(
  parameter int           W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_r;
  logic [W-1:0] q_r;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_r <= RST;
      q_r    <= RST;
    end else begin
      meta_r <= d;
      q_r    <= meta_r;
    end
  end

  assign q = q_r;

endmodule : vpof_sync2
`default_nettype wire

// [core/vpof_black_level.sv]
// black-level averaging and loop filter, three channels
// runs on the pixel clock; take marks each accepted pixel
`timescale 1ns/1ps
`default_nettype none
module vpof_black_level
  import vpof_pkg::*;
#(
  parameter int W = 8
) (
  input  wire logic           clk,
  input  wire logic           rst_b,
  input  wire logic           take,
  input  wire logic           line_sync_in,
  input  wire logic [3*W-1:0] samples,
  input  wire logic           dis,
  input  wire logic [1:0]     avg_sel,
  input  wire logic [2:0]     bw,
  input  wire logic [12:0]    start,
  output logic      [3*W-1:0] lvl_snap,
  output logic                lvl_tgl
);

  typedef enum logic [1:0] {BL_IDLE, BL_WAIT, BL_SUM} vpof_bl_state_t;

  vpof_bl_state_t st_r;
  logic           ls_prev_r;
  logic [12:0]    pos_r;
  logic [7:0]     n_r;
  logic [7:0]     n_last;
  logic           trail;
  logic           done;
  logic [3*W-1:0] snap_r;
  logic           tgl_r;

  assign trail  = take && ls_prev_r && !line_sync_in;
  assign n_last = 8'((16 << avg_sel) - 1);
  assign done   = take && (st_r == BL_SUM) && (n_r == n_last);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ls_prev_r <= 1'b0;
    end else if (take) begin
      ls_prev_r <= line_sync_in;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r  <= BL_IDLE;
      pos_r <= 13'h0000;
      n_r   <= 8'h00;
    end else if (dis) begin
      st_r <= BL_IDLE;
    end else if (trail) begin
      st_r  <= (start == 13'h0000) ? BL_SUM : BL_WAIT;
      pos_r <= 13'h0001;
      n_r   <= 8'h00;
    end else if (take) begin
      unique case (st_r)
        BL_IDLE: ;
        BL_WAIT: begin
          if (pos_r == start) begin
            st_r <= BL_SUM;
          end
          pos_r <= pos_r + 13'h0001;
        end
        BL_SUM: begin
          if (done) begin
            st_r <= BL_IDLE;
          end
          n_r <= n_r + 8'h01;
        end
      endcase
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_chan
      logic [W+6:0]          acc_r;
      logic [W+6:0]          acc_nxt;
      logic [W+BLC_FRAC-1:0] lvl_r;
      logic [W+BLC_FRAC-1:0] lvl_nxt;
      logic [W-1:0]          avg;
      logic signed [W+BLC_FRAC:0] diff;

      assign acc_nxt = acc_r + (W+7)'(samples[gi*W +: W]);
      assign avg     = W'(acc_nxt >> (BLC_MIN_AVG_EXP + avg_sel));
      assign diff    = $signed({1'b0, avg, {BLC_FRAC{1'b0}}}) - $signed({1'b0, lvl_r});
      assign lvl_nxt = lvl_r + (W+BLC_FRAC)'(diff >>> (BLC_TC_BASE_EXP + bw));

      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          acc_r <= '0;
        end else if (trail || (st_r != BL_SUM)) begin
          acc_r <= '0;
        end else if (take) begin
          acc_r <= done ? '0 : acc_nxt;
        end
      end

      // first-order loop, time constant 2^(5+bw) lines
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          lvl_r <= '0;
        end else if (done && !dis) begin
          lvl_r <= lvl_nxt;
        end
      end

      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          snap_r[gi*W +: W] <= '0;
        end else if (done && !dis) begin
          snap_r[gi*W +: W] <= lvl_nxt[BLC_FRAC +: W];
        end
      end

      a_level_hold: assert property (@(posedge clk) disable iff (!rst_b)
        dis |=> $stable(lvl_r)) else $error("black level moved while disabled");
    end
  endgenerate

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tgl_r <= 1'b0;
    end else if (done && !dis) begin
      tgl_r <= ~tgl_r;
    end
  end

  assign lvl_snap = snap_r;
  assign lvl_tgl  = tgl_r;

  a_avg_count: assert property (@(posedge clk) disable iff (!rst_b)
    done |-> (n_r == 8'(16 << avg_sel) - 8'h01))
    else $error("averaging window length wrong");

  a_start_pixel: assert property (@(posedge clk) disable iff (!rst_b)
    (!dis && !trail && take && st_r == BL_WAIT && pos_r == start) |=> st_r == BL_SUM)
    else $error("averaging did not begin at start pixel");

endmodule : vpof_black_level
`default_nettype wire

// [core/vpof_top.sv]
// output formatter: pixel buses, sync outputs, data clock, black-level control
// assumes registers on mclk, pixels on pix_clk taken every second pix_clk cycle
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - black-level compensation runs while its disable bit is 0 and stops when it is 1.
// - each line averages 16, 32, 64 or 128 black pixels as the 2-bit width field selects.
// - the loop time constant is 2^(5+bandwidth field) lines, 512 lines at reset.
// - in 24-bit mode only primary buses carry data and secondary buses are held low.
// - in 48-bit mode secondary data changes on the primary edge, or the opposite one if interleaved.
// - in 48-bit mode the first pixel after the line sync pulse goes primary, or secondary if swapped.
// - in 24-bit mode the output is 4:4:4, or 4:2:2 with the blue bus low when decimation is set.
// - syncs and primary pixel data change on the data clock falling edge, or rising edge when inverted.
// - frame and line sync outputs are active high by default and active low when inverted.
// - the line sync pulse lasts the programmed number of pixels, at least 1 (24-bit) or 2 (48-bit).
// - each byte bus floats while its disable bit is 1, overriding every other setting.
// - the data clock floats while either of its disable bits is 1.
// - averaging starts a programmed 13-bit pixel count after the incoming line sync ends.
module vpof_top
  import vpof_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       rst_b,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       pix_clk,
  input  wire logic [7:0] sample_red,
  input  wire logic [7:0] sample_green,
  input  wire logic [7:0] sample_blue,
  input  wire logic       line_sync_in,
  input  wire logic       frame_sync_in,
  output logic            sample_take,
  output logic      [7:0] red_primary_bus,
  output logic            red_primary_bus_oe,
  output logic      [7:0] red_secondary_bus,
  output logic            red_secondary_bus_oe,
  output logic      [7:0] green_primary_bus,
  output logic            green_primary_bus_oe,
  output logic      [7:0] green_secondary_bus,
  output logic            green_secondary_bus_oe,
  output logic      [7:0] blue_primary_bus,
  output logic            blue_primary_bus_oe,
  output logic      [7:0] blue_secondary_bus,
  output logic            blue_secondary_bus_oe,
  output logic            line_sync_out,
  output logic            frame_sync_out,
  output logic            output_data_clock,
  output logic            output_data_clock_oe
);

  localparam int CFG_W = 45;
  localparam logic [CFG_W-1:0] CFG_RST = {RST_START, RST_TRISTATE, RST_LS_WIDTH,
                                          RST_OUT_FMT, RST_BLACK_CFG};

  ////////////////////////////////////////////////////////////////////////////
  // register port, mclk domain

  logic [7:0]  black_cfg_r;
  logic [7:0]  out_fmt_r;
  logic [7:0]  ls_width_r;
  logic [7:0]  tristate_r;
  logic [12:0] start_r;
  logic [7:0]  rdata_r;
  logic [23:0] lvl_m_r;
  logic        lvl_tgl_m;
  logic        lvl_tgl_prev_r;
  logic [23:0] lvl_snap;
  logic        lvl_tgl;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      black_cfg_r <= RST_BLACK_CFG;
      out_fmt_r   <= RST_OUT_FMT;
      ls_width_r  <= RST_LS_WIDTH;
      tristate_r  <= RST_TRISTATE;
      start_r     <= RST_START;
    end else if (reg_wr) begin
      case (reg_addr)
        ADDR_START_MSB: start_r[12:8] <= 5'(reg_wdata & MASK_START_MSB);
        ADDR_START_LSB: start_r[7:0]  <= reg_wdata;
        ADDR_BLACK_CFG: black_cfg_r   <= reg_wdata & MASK_BLACK_CFG;
        ADDR_OUT_FMT:   out_fmt_r     <= reg_wdata & MASK_OUT_FMT;
        ADDR_LS_WIDTH:  ls_width_r    <= reg_wdata;
        ADDR_TRISTATE:  tristate_r    <= reg_wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_r <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        ADDR_START_MSB:   rdata_r <= {3'h0, start_r[12:8]};
        ADDR_START_LSB:   rdata_r <= start_r[7:0];
        ADDR_BLACK_CFG:   rdata_r <= black_cfg_r;
        ADDR_OUT_FMT:     rdata_r <= out_fmt_r;
        ADDR_LS_WIDTH:    rdata_r <= ls_width_r;
        ADDR_TRISTATE:    rdata_r <= tristate_r;
        ADDR_LEVEL_RED:   rdata_r <= lvl_m_r[23:16];
        ADDR_LEVEL_GREEN: rdata_r <= lvl_m_r[15:8];
        ADDR_LEVEL_BLUE:  rdata_r <= lvl_m_r[7:0];
        default:          rdata_r <= 8'h00;
      endcase
    end else begin
      rdata_r <= 8'h00;
    end
  end

  assign reg_rdata = rdata_r;

  // level snapshot crosses by toggle; the snapshot is stable for a whole line
  vpof_sync2 #(.W(1), .RST(1'b0)) u_lvl_sync (
    .clk   (mclk),
    .rst_b (rst_b),
    .d     (lvl_tgl),
    .q     (lvl_tgl_m)
  );

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      lvl_tgl_prev_r <= 1'b0;
      lvl_m_r        <= 24'h000000;
    end else begin
      lvl_tgl_prev_r <= lvl_tgl_m;
      if (lvl_tgl_m != lvl_tgl_prev_r) begin
        lvl_m_r <= lvl_snap;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pixel-clock reset and configuration crossing

  logic [1:0]       prst_r;
  logic             pix_rst_b;
  logic [CFG_W-1:0] cfg_p;

  always_ff @(posedge pix_clk or negedge rst_b) begin
    if (!rst_b) begin
      prst_r <= 2'b00;
    end else begin
      prst_r <= {prst_r[0], 1'b1};
    end
  end

  assign pix_rst_b = prst_r[1];

  vpof_sync2 #(.W(CFG_W), .RST(CFG_RST)) u_cfg_sync (
    .clk   (pix_clk),
    .rst_b (rst_b),
    .d     ({start_r, tristate_r, ls_width_r, out_fmt_r, black_cfg_r}),
    .q     (cfg_p)
  );

  logic [7:0]  blc_p;
  logic [7:0]  fmt_p;
  logic [7:0]  width_p;
  logic [7:0]  ts_p;
  logic [12:0] start_p;
  logic        wide;
  logic        il;
  logic        swap;
  logic        dec;

  assign blc_p   = cfg_p[7:0];
  assign fmt_p   = cfg_p[15:8];
  assign width_p = cfg_p[23:16];
  assign ts_p    = cfg_p[31:24];
  assign start_p = cfg_p[44:32];
  assign wide    = fmt_p[FMT_WIDE_BIT];
  assign il      = wide && fmt_p[FMT_IL_BIT];
  assign swap    = wide && fmt_p[FMT_SWAP_BIT];
  assign dec     = !wide && fmt_p[FMT_DEC_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // data clock phase and update events

  logic [1:0] ph_r;
  logic [1:0] ph_nxt;
  logic       base_r;
  logic       base_nxt;
  logic       dclk_r;
  logic       take;
  logic       upd_p;
  logic       upd_s;

  assign ph_nxt      = ph_r + 2'b01;
  assign base_nxt    = wide ? ph_nxt[1] : ph_nxt[0];
  assign take        = ph_r[0];
  assign sample_take = take;
  assign upd_p       = base_r && !base_nxt;
  assign upd_s       = il ? (!base_r && base_nxt) : upd_p;

  always_ff @(posedge pix_clk or negedge pix_rst_b) begin
    if (!pix_rst_b) begin
      ph_r   <= 2'b00;
      base_r <= 1'b0;
      dclk_r <= 1'b0;
    end else begin
      ph_r   <= ph_nxt;
      base_r <= base_nxt;
      dclk_r <= fmt_p[FMT_DCLK_POL_BIT] ? !base_nxt : base_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // line sync pulse and pixel steering

  logic       ls_prev_r;
  logic       ls_rise;
  logic [7:0] ls_cnt_r;
  logic [7:0] ls_cnt_nxt;
  logic [7:0] ls_len_r;
  logic       sel_r;
  logic       chroma_r;
  logic       ls_out_r;
  logic       fs_out_r;

  assign ls_rise = take && line_sync_in && !ls_prev_r;

  always_comb begin
    ls_cnt_nxt = ls_cnt_r;
    if (ls_rise) begin
      ls_cnt_nxt = width_p;
    end else if (take && ls_cnt_r != 8'h00) begin
      ls_cnt_nxt = ls_cnt_r - 8'h01;
    end
  end

  always_ff @(posedge pix_clk or negedge pix_rst_b) begin
    if (!pix_rst_b) begin
      ls_prev_r <= 1'b0;
      ls_cnt_r  <= 8'h00;
    end else begin
      ls_cnt_r <= ls_cnt_nxt;
      if (take) begin
        ls_prev_r <= line_sync_in;
      end
    end
  end

  // pixels in the current pulse, watched only by a_ls_width
  always_ff @(posedge pix_clk or negedge pix_rst_b) begin
    if (!pix_rst_b) begin
      ls_len_r <= 8'h00;
    end else if (ls_rise) begin
      ls_len_r <= 8'h01;
    end else if (take && ls_cnt_r != 8'h00 && ls_len_r != 8'hFF) begin
      ls_len_r <= ls_len_r + 8'h01;
    end
  end

  always_ff @(posedge pix_clk or negedge pix_rst_b) begin
    if (!pix_rst_b) begin
      sel_r    <= 1'b0;
      chroma_r <= 1'b0;
    end else if (take) begin
      if (ls_cnt_r == 8'h01 && !ls_rise) begin
        sel_r    <= swap;
        chroma_r <= 1'b0;
      end else begin
        sel_r    <= !sel_r;
        chroma_r <= !chroma_r;
      end
    end
  end

  always_ff @(posedge pix_clk or negedge pix_rst_b) begin
    if (!pix_rst_b) begin
      ls_out_r <= 1'b0;
      fs_out_r <= 1'b0;
    end else if (upd_p) begin
      ls_out_r <= (ls_cnt_nxt != 8'h00) ^ fmt_p[FMT_LS_POL_BIT];
      fs_out_r <= frame_sync_in ^ fmt_p[FMT_FS_POL_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pixel data registers

  logic [23:0] pix_in;
  logic [23:0] fmt24;
  logic [23:0] hp_r;
  logic [23:0] hs_r;
  logic [23:0] hp_nxt;
  logic [23:0] hs_nxt;
  logic [23:0] prim_r;
  logic [23:0] sec_r;

  assign pix_in = {sample_red, sample_green, sample_blue};
  assign fmt24  = dec ? {(chroma_r ? sample_blue : sample_red), sample_green, 8'h00}
                      : pix_in;
  assign hp_nxt = (take && !sel_r) ? pix_in : hp_r;
  assign hs_nxt = (take && sel_r) ? pix_in : hs_r;

  always_ff @(posedge pix_clk or negedge pix_rst_b) begin
    if (!pix_rst_b) begin
      hp_r <= 24'h000000;
      hs_r <= 24'h000000;
    end else begin
      hp_r <= hp_nxt;
      hs_r <= hs_nxt;
    end
  end

  always_ff @(posedge pix_clk or negedge pix_rst_b) begin
    if (!pix_rst_b) begin
      prim_r <= 24'h000000;
    end else if (upd_p) begin
      prim_r <= wide ? hp_nxt : fmt24;
    end
  end

  always_ff @(posedge pix_clk or negedge pix_rst_b) begin
    if (!pix_rst_b) begin
      sec_r <= 24'h000000;
    end else if (!wide) begin
      sec_r <= 24'h000000;
    end else if (upd_s) begin
      sec_r <= hs_nxt;
    end
  end

  assign red_primary_bus        = prim_r[23:16];
  assign green_primary_bus      = prim_r[15:8];
  assign blue_primary_bus       = prim_r[7:0];
  assign red_secondary_bus      = sec_r[23:16];
  assign green_secondary_bus    = sec_r[15:8];
  assign blue_secondary_bus     = sec_r[7:0];
  assign red_primary_bus_oe     = !ts_p[0];
  assign red_secondary_bus_oe   = !ts_p[1];
  assign green_primary_bus_oe   = !ts_p[2];
  assign green_secondary_bus_oe = !ts_p[3];
  assign blue_primary_bus_oe    = !ts_p[4];
  assign blue_secondary_bus_oe  = !ts_p[5];
  assign output_data_clock_oe   = !(ts_p[TS_DCLK_A_BIT] || ts_p[TS_DCLK_B_BIT]);
  assign output_data_clock      = dclk_r;
  assign line_sync_out          = ls_out_r;
  assign frame_sync_out         = fs_out_r;

  ////////////////////////////////////////////////////////////////////////////
  // black-level averaging

  vpof_black_level #(.W(8)) u_black (
    .clk          (pix_clk),
    .rst_b        (pix_rst_b),
    .take         (take),
    .line_sync_in (line_sync_in),
    .samples      (pix_in),
    .dis          (blc_p[BLC_DIS_BIT]),
    .avg_sel      (blc_p[BLC_PIX_LSB +: 2]),
    .bw           (blc_p[BLC_BW_LSB +: 3]),
    .start        (start_p),
    .lvl_snap     (lvl_snap),
    .lvl_tgl      (lvl_tgl)
  );

  ////////////////////////////////////////////////////////////////////////////
  // checks

  sequence s_line_end;
    take && ls_cnt_r == 8'h01 && !ls_rise;
  endsequence

  sequence s_line_start;
    ls_rise && width_p != 8'h00;
  endsequence

  a_sec_low: assert property (@(posedge pix_clk) disable iff (!pix_rst_b)
    !wide |=> (sec_r == 24'h000000 || wide))
    else $error("secondary bus not low in 24-bit mode");

  a_blue_dec: assert property (@(posedge pix_clk) disable iff (!pix_rst_b)
    (dec && upd_p) |=> blue_primary_bus == 8'h00)
    else $error("blue bus not low in 4:2:2");

  a_data_edge: assert property (@(posedge pix_clk) disable iff (!pix_rst_b)
    $changed(prim_r) |-> $past(upd_p) && ($past(base_r) != $past(base_nxt)))
    else $error("primary data changed off the update edge");

  a_same_edge: assert property (@(posedge pix_clk) disable iff (!pix_rst_b)
    (wide && !il && upd_s) |-> upd_p)
    else $error("secondary edge differs without interleave");

  a_interleave_edge: assert property (@(posedge pix_clk) disable iff (!pix_rst_b)
    (il && upd_s) |-> !upd_p ##1 (dclk_r == fmt_p[FMT_DCLK_POL_BIT] ^ 1'b1))
    else $error("interleaved data not on opposite edge");

  a_ls_width: assert property (@(posedge pix_clk) disable iff (!pix_rst_b)
    s_line_end |-> ls_len_r == width_p)
    else $error("line sync pulse width wrong");

  a_ls_active: assert property (@(posedge pix_clk) disable iff (!pix_rst_b)
    (s_line_start ##0 upd_p) |=> line_sync_out != fmt_p[FMT_LS_POL_BIT])
    else $error("line sync not asserted at its polarity");

  a_swap_first: assert property (@(posedge pix_clk) disable iff (!pix_rst_b)
    s_line_end |=> sel_r == swap)
    else $error("first pixel bus choice wrong after line sync");

  a_alternate: assert property (@(posedge pix_clk) disable iff (!pix_rst_b)
    (take && !(ls_cnt_r == 8'h01) && !ls_rise) |=> sel_r != $past(sel_r))
    else $error("pixels did not alternate between bus sets");

  a_oe_override: assert property (@(posedge pix_clk) disable iff (!pix_rst_b)
    ts_p[4] |-> !blue_primary_bus_oe ##1 (ts_p[4] ? !blue_primary_bus_oe : 1'b1))
    else $error("disabled byte bus still driven");

  a_clk_float: assert property (@(posedge pix_clk) disable iff (!pix_rst_b)
    ts_p[TS_DCLK_B_BIT] |-> !output_data_clock_oe)
    else $error("data clock driven while disabled");

endmodule : vpof_top
`default_nettype wire

// [dv/vpof_scaler_model.sv]
// downstream scaler model: resolves the byte lanes, captures them
// assumes bus packs {bs,bp,gs,gp,rs,rp}, oe high means driven
`timescale 1ns/1ps
`default_nettype none
module vpof_scaler_model (
  input  wire logic [47:0] bus,
  input  wire logic [5:0]  oe,
  input  wire logic        dclk,
  input  wire logic        dclk_oe,
  output logic      [47:0] pins,
  output logic      [47:0] seen
);
  // released lanes fall to the pull-down level
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      pins[8*i +: 8] = oe[i] ? bus[8*i +: 8] : 8'h00;
    end
  end
  // capture on rising clock, away from the falling launch
  always_ff @(posedge dclk) begin
    if (dclk_oe) begin
      seen <= pins;
    end
  end
endmodule : vpof_scaler_model
`default_nettype wire

// [dv/testbench.sv]
// self-checking bench: registers, formats, syncs, tristates
// assumes the formatter top and the scaler model
`timescale 1ns/1ps
`default_nettype none
module testbench import vpof_pkg::*;;
  logic mclk = 0, pix_clk = 0, rst_b = 0, reg_wr = 0, reg_rd = 0, rd_d = 0, fix = 0;
  logic line_sync_in = 0, frame_sync_in = 0;
  logic [7:0] reg_addr = 0, reg_wdata = 0, sr = 0, sg = 0, sb = 0, v;
  logic [7:0] reg_rdata, rp, rs, gp, gs, bp, bs;
  logic [5:0] oe;
  logic ls_o, fs_o, dclk, dclk_oe, take;
  logic [47:0] pins, seen;
  logic [7:0] exp_q[$];
  int fails = 0, check_count = 0, n, m;
  initial forever #50 mclk = ~mclk;
  initial begin
    #7;
    forever #15 pix_clk = ~pix_clk;
  end
  always @(posedge pix_clk) begin
    sr <= fix ? 8'hFF : 8'($urandom);
    sg <= fix ? 8'hFF : 8'($urandom);
    sb <= fix ? 8'hFF : 8'($urandom);
  end
  vpof_top u_dut (.mclk(mclk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pix_clk(pix_clk),
    .sample_red(sr), .sample_green(sg), .sample_blue(sb), .line_sync_in(line_sync_in),
    .frame_sync_in(frame_sync_in), .sample_take(take), .red_primary_bus(rp),
    .red_primary_bus_oe(oe[0]), .red_secondary_bus(rs), .red_secondary_bus_oe(oe[1]),
    .green_primary_bus(gp), .green_primary_bus_oe(oe[2]), .green_secondary_bus(gs),
    .green_secondary_bus_oe(oe[3]), .blue_primary_bus(bp), .blue_primary_bus_oe(oe[4]),
    .blue_secondary_bus(bs), .blue_secondary_bus_oe(oe[5]), .line_sync_out(ls_o),
    .frame_sync_out(fs_o), .output_data_clock(dclk), .output_data_clock_oe(dclk_oe));
  vpof_scaler_model u_scaler (.bus({bs, bp, gs, gp, rs, rp}), .oe(oe), .dclk(dclk),
    .dclk_oe(dclk_oe), .pins(pins), .seen(seen));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    exp_q.push_back(e);
    @(posedge mclk);
    reg_rd <= 1'b0;
  endtask : rd
  task automatic settle;
    repeat (16) @(posedge pix_clk);
    @(negedge pix_clk);
  endtask : settle
  // one incoming line and frame pulse of 10 pix_clk, output highs counted
  task automatic pulse;
    n = 0;
    m = 0;
    for (int i = 0; i < 60; i++) begin
      @(posedge pix_clk);
      line_sync_in <= (i < 10);
      frame_sync_in <= (i < 10);
      @(negedge pix_clk);
      if (ls_o === 1'b1) n++;
      if (fs_o === 1'b1) m++;
    end
  endtask : pulse
  task automatic wrap_up;
    $display("checks=%0d fails=%0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : wrap_up
  // read data stands only in the cycle after the strobe
  always @(posedge mclk) rd_d <= reg_rd;
  always @(negedge mclk) begin
    if (rd_d) begin
      chk(reg_rdata, exp_q.pop_front());
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'hA0E7));
    repeat (10) @(posedge mclk);
    rst_b <= 1'b1;
    rd(8'h17, 8'h40);
    rd(8'h18, 8'h00);
    rd(8'h19, 8'h10);
    rd(8'h1A, 8'h00);
    wr(8'h17, 8'hFF);
    rd(8'h17, 8'h7D);
    wr(8'h18, 8'hFF);
    rd(8'h18, 8'hF7);
    rd(8'h30, 8'h00);
    wr(8'h18, 8'h10);
    settle();
    chk(bp, 8'h00);
    chk(seen & 48'hFF00FF00FF00, 48'h0);
    wr(8'h18, 8'hC0);
    settle();
    chk({ls_o, fs_o}, 2'b11);
    wr(8'h18, 8'h00);
    wr(8'h19, 8'h03);
    wr(8'h17, 8'h00);
    wr(8'h15, 8'h02);
    rd(8'h15, 8'h02);
    fix = 1'b1;
    settle();
    pulse();
    chk(n, 6);
    chk(m, 10);
    settle();
    chk(seen & 48'h00FF00FF00FF, 48'h00FF00FF00FF);
    // one line at a 32-line time constant lifts the level by a 32nd of 0xFF
    rd(8'h40, 8'h07);
    rd(8'h41, 8'h07);
    rd(8'h42, 8'h07);
    wr(8'h17, 8'h01);
    settle();
    pulse();
    settle();
    rd(8'h40, 8'h07);
    fix = 1'b0;
    v = 8'($urandom);
    wr(8'h1A, v);
    settle();
    chk(oe, 6'(~v[5:0]));
    chk(dclk_oe, !(v[6] | v[7]));
    wrap_up();
  end
endmodule : testbench
`default_nettype wire
